// ===== rtl/cbw_pkg.sv
// constants and types for the card bus window decode register bank
// Summary of operation
// - memory limit bits 31..12 are writable
// - memory limit bits 11..0 read zero
// - memory window off while base and limit zero
// - prefetch flags follow bridge control bits 8, 9
// - memory windows decode both directions
// - io base bits 31..16, 1..0 read zero
// - io windows decode both directions
// - io limit bits 15..2 are writable
// - io limit upper half zero, page from base
// - io limit low bits read zero, compare as ones
// - io window off while base and limit zero
// - read-only io limit bits ignore writes
// - line byte is writable, resets FF, unused
// - function zero pin byte read-only, value one
// - pin value stays one under both tie settings
package cbw_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_MBASE0 = 8'h1C;
  localparam logic [7:0] OFS_MLIM0  = 8'h20;
  localparam logic [7:0] OFS_MBASE1 = 8'h24;
  localparam logic [7:0] OFS_MLIM1  = 8'h28;
  localparam logic [7:0] OFS_IOB0   = 8'h2C;
  localparam logic [7:0] OFS_IOL0   = 8'h30;
  localparam logic [7:0] OFS_IOB1   = 8'h34;
  localparam logic [7:0] OFS_IOL1   = 8'h38;
  localparam logic [7:0] OFS_IRQ    = 8'h3C;
  localparam logic [7:0] OFS_TIE    = 8'h40;
  // writable bit masks per register
  localparam logic [31:0] MEM_WMASK = 32'hFFFF_F000;
  localparam logic [31:0] IO_WMASK  = 32'h0000_FFFC;
  localparam logic [31:0] IRQ_WMASK = 32'h0300_00FF;
  localparam logic [31:0] TIE_WMASK = 32'h0000_0003;
  // field positions
  localparam int LINE_LSB = 0;
  localparam int PIN_LSB  = 8;
  localparam int PF0_BIT  = 24;
  localparam int PF1_BIT  = 25;
  localparam int TIE2_BIT = 0;
  localparam int TALL_BIT = 1;
  // values after reset
  localparam logic [31:0] RST_WIN  = 32'h0000_0000;
  localparam logic [7:0]  RST_LINE = 8'hFF;
  localparam logic [1:0]  RST_PF   = 2'h3;
  localparam logic [1:0]  RST_TIE  = 2'h0;
  // unimplemented low bits of each limit
  localparam int MEM_LOW_BITS = 12;
  localparam int IO_LOW_BITS  = 2;
  // interrupt pin codes
  localparam logic [7:0] PIN_A = 8'h01;
  localparam logic [7:0] PIN_B = 8'h02;
  localparam logic [7:0] PIN_C = 8'h03;
  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // register selector
  typedef enum {SEL_MBASE0, SEL_MBASE1, SEL_MLIM0, SEL_MLIM1,
                SEL_IOB0, SEL_IOB1, SEL_IOL0, SEL_IOL1,
                SEL_IRQ, SEL_TIE, SEL_NONE} cbw_sel_type;
endpackage

// ===== rtl/cbw_window_match.sv
// one address window comparator
`timescale 1ns/1ps
module cbw_window_match
  import cbw_pkg::*;
#(
  parameter int LOW_BITS = MEM_LOW_BITS
)(
  input  wire logic [31:0] BASE,
  input  wire logic [31:0] LIMIT,
  input  wire logic [31:0] ADDR,
  output logic             HIT
);
  // limit with its dropped low bits forced high
  logic [31:0] top_lim;
  // window enable
  logic        win_on;

  if (LOW_BITS < 1 || LOW_BITS > 31)
  begin : g_chk
    $error("LOW_BITS out of range");
  end

  // pad the limit so it covers its whole granule
  assign top_lim = LIMIT | ((32'h1 << LOW_BITS) - 32'h1);
  // all-zero window stays closed after reset
  assign win_on = (BASE != 32'h0) || (LIMIT != 32'h0);

  // inclusive compare at both ends
  always_comb
  begin
    HIT = win_on && (ADDR >= BASE) && (ADDR <= top_lim);
  end
endmodule // cbw_window_match

// ===== rtl/cbw_regs.sv
// window decode registers with axi4-lite access and hit outputs
`timescale 1ns/1ps
module cbw_regs
  import cbw_pkg::*;
#(
  parameter int NWIN = 2
)(
  input  wire logic        CORE_CLK,
  input  wire logic        RST,
  input  wire logic        CLK_EN,
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  input  wire logic [31:0] PCI_MEM_ADDR,
  input  wire logic [31:0] PCI_IO_ADDR,
  input  wire logic [31:0] CB_MEM_ADDR,
  input  wire logic [31:0] CB_IO_ADDR,
  output logic [1:0]       DN_MEM_HIT,
  output logic [1:0]       DN_MEM_PREFETCH,
  output logic [1:0]       UP_MEM_HIT,
  output logic [1:0]       DN_IO_HIT,
  output logic [1:0]       UP_IO_HIT,
  output logic             TIE_SECOND_IRQ_TO_FIRST,
  output logic             TIE_ALL_IRQ_LINES
);
  // the selector enum and ports are sized for two windows
  if (NWIN != 2)
  begin : g_chk
    $error("NWIN must be 2");
  end

  // window registers
  logic [31:0] mbase_q [2];  // memory lower bounds
  logic [31:0] mlim_q  [2];  // memory upper bounds
  logic [31:0] iob_q   [2];  // io lower bounds
  logic [31:0] iol_q   [2];  // io upper bounds
  logic [7:0]  line_q;       // interrupt line byte
  logic [1:0]  pf_q;         // prefetch flags
  logic [1:0]  tie_q;        // interrupt tie settings
  // write channel holding
  logic [7:0]  awaddr_q;     // captured write address
  logic        aw_have_q;    // address held
  logic [31:0] wdata_q;      // captured write data
  logic [3:0]  wstrb_q;      // captured strobes
  logic        w_have_q;     // data held
  logic        bvalid_q;     // write response pending
  logic [1:0]  bresp_q;      // write response code
  // read channel
  logic        rvalid_q;     // read data pending
  logic [31:0] rdata_q;      // read data
  logic [1:0]  rresp_q;      // read response code
  // decode
  logic        wr_go;        // write commits this cycle
  cbw_sel_type wr_sel;       // write target
  cbw_sel_type rd_sel;       // read target
  logic        rd_go;        // read accepted this cycle
  logic [7:0]  pin_f0;       // function zero pin byte
  // raw comparator hits
  logic [1:0]  dn_mem_c;
  logic [1:0]  up_mem_c;
  logic [1:0]  dn_io_c;
  logic [1:0]  up_io_c;
  logic [31:0] io_top [2];   // io limit with base page
  logic [31:0] irq_wr;       // merged image of the interrupt word
  logic [31:0] tie_wr;       // merged image of the tie word

  // address to register selector
  function automatic cbw_sel_type sel_of(input logic [7:0] a);
    logic [7:0] w;
    w = {a[7:2], 2'b00};
    if (w == OFS_MBASE0)
      sel_of = SEL_MBASE0;
    else if (w == OFS_MBASE1)
      sel_of = SEL_MBASE1;
    else if (w == OFS_MLIM0)
      sel_of = SEL_MLIM0;
    else if (w == OFS_MLIM1)
      sel_of = SEL_MLIM1;
    else if (w == OFS_IOB0)
      sel_of = SEL_IOB0;
    else if (w == OFS_IOB1)
      sel_of = SEL_IOB1;
    else if (w == OFS_IOL0)
      sel_of = SEL_IOL0;
    else if (w == OFS_IOL1)
      sel_of = SEL_IOL1;
    else if (w == OFS_IRQ)
      sel_of = SEL_IRQ;
    else if (w == OFS_TIE)
      sel_of = SEL_TIE;
    else
      sel_of = SEL_NONE;
  endfunction

  // byte-lane merge limited to writable bits
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] d,
                                        input logic [3:0]  s,
                                        input logic [31:0] wm);
    logic [31:0] bm;
    bm = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}} & wm;
    merge = (old & ~bm) | (d & bm);
  endfunction

  // pin code per function under the tie settings
  function automatic logic [7:0] pin_of(input int fn,
                                        input logic t2,
                                        input logic tall);
    if (tall || fn == 0)
      pin_of = PIN_A;
    else if (fn == 1)
      pin_of = t2 ? PIN_A : PIN_B;
    else
      pin_of = PIN_C;
  endfunction

  // handshakes; nothing is taken while frozen
  assign S_AXI_AWREADY = CLK_EN && !aw_have_q;
  assign S_AXI_WREADY  = CLK_EN && !w_have_q;
  assign S_AXI_ARREADY = CLK_EN && !rvalid_q;
  assign S_AXI_BVALID  = bvalid_q;
  assign S_AXI_BRESP   = bresp_q;
  assign S_AXI_RVALID  = rvalid_q;
  assign S_AXI_RDATA   = rdata_q;
  assign S_AXI_RRESP   = rresp_q;

  // commit once both halves are here and no response waits
  assign wr_go  = CLK_EN && aw_have_q && w_have_q && !bvalid_q;
  assign wr_sel = sel_of(awaddr_q);
  assign rd_go  = S_AXI_ARVALID && S_AXI_ARREADY;
  assign rd_sel = sel_of(S_AXI_ARADDR);
  // function zero always reports the first line
  assign pin_f0 = pin_of(0, tie_q[TIE2_BIT], tie_q[TALL_BIT]);
  // whole-word images so only the stored fields are picked out below
  assign irq_wr = merge({6'h0, pf_q, 16'h0000, line_q}, wdata_q, wstrb_q, IRQ_WMASK);
  assign tie_wr = merge({30'h0, tie_q}, wdata_q, wstrb_q, TIE_WMASK);

  // write address capture, either order with data
  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      aw_have_q <= 1'b0;
      awaddr_q  <= 8'h00;
    end
    else if (CLK_EN)
    begin
      if (S_AXI_AWVALID && !aw_have_q)
      begin
        aw_have_q <= 1'b1;
        awaddr_q  <= S_AXI_AWADDR;
      end
      else if (wr_go)
        aw_have_q <= 1'b0;
    end
  end

  // write data capture
  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      w_have_q <= 1'b0;
      wdata_q  <= 32'h0000_0000;
      wstrb_q  <= 4'h0;
    end
    else if (CLK_EN)
    begin
      if (S_AXI_WVALID && !w_have_q)
      begin
        w_have_q <= 1'b1;
        wdata_q  <= S_AXI_WDATA;
        wstrb_q  <= S_AXI_WSTRB;
      end
      else if (wr_go)
        w_have_q <= 1'b0;
    end
  end

  // write response; unmapped offsets answer slverr
  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end
    else if (CLK_EN)
    begin
      if (wr_go)
      begin
        bvalid_q <= 1'b1;
        bresp_q  <= (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      end
      else if (S_AXI_BREADY)
        bvalid_q <= 1'b0;
    end
  end

  // window bound registers, one pair set per window
  for (genvar i = 0; i < 2; i++)
  begin : g_win
    // memory bounds keep only the 4k page bits
    always_ff @(posedge CORE_CLK)
    begin
      if (RST)
      begin
        mbase_q[i] <= RST_WIN;
        mlim_q[i]  <= RST_WIN;
      end
      else if (CLK_EN && wr_go)
      begin
        if (wr_sel == (i == 0 ? SEL_MBASE0 : SEL_MBASE1))
          mbase_q[i] <= merge(mbase_q[i], wdata_q, wstrb_q, MEM_WMASK);
        else if (wr_sel == (i == 0 ? SEL_MLIM0 : SEL_MLIM1))
          mlim_q[i] <= merge(mlim_q[i], wdata_q, wstrb_q, MEM_WMASK);
      end
    end

    // io bounds keep dword bits of the first page only
    always_ff @(posedge CORE_CLK)
    begin
      if (RST)
      begin
        iob_q[i] <= RST_WIN;
        iol_q[i] <= RST_WIN;
      end
      else if (CLK_EN && wr_go)
      begin
        if (wr_sel == (i == 0 ? SEL_IOB0 : SEL_IOB1))
          iob_q[i] <= merge(iob_q[i], wdata_q, wstrb_q, IO_WMASK);
        else if (wr_sel == (i == 0 ? SEL_IOL0 : SEL_IOL1))
          iol_q[i] <= merge(iol_q[i], wdata_q, wstrb_q, IO_WMASK);
      end
    end

    // io top takes its page from the base register
    assign io_top[i] = {iob_q[i][31:16], iol_q[i][15:0]};

    // downstream memory decode
    cbw_window_match #(.LOW_BITS(MEM_LOW_BITS)) u_dn_mem (
      .BASE  (mbase_q[i]),
      .LIMIT (mlim_q[i]),
      .ADDR  (PCI_MEM_ADDR),
      .HIT   (dn_mem_c[i])
    );
    // upstream memory decode on the same range
    cbw_window_match #(.LOW_BITS(MEM_LOW_BITS)) u_up_mem (
      .BASE  (mbase_q[i]),
      .LIMIT (mlim_q[i]),
      .ADDR  (CB_MEM_ADDR),
      .HIT   (up_mem_c[i])
    );
    // downstream io decode
    cbw_window_match #(.LOW_BITS(IO_LOW_BITS)) u_dn_io (
      .BASE  (iob_q[i]),
      .LIMIT (io_top[i]),
      .ADDR  (PCI_IO_ADDR),
      .HIT   (dn_io_c[i])
    );
    // upstream io decode on the same range
    cbw_window_match #(.LOW_BITS(IO_LOW_BITS)) u_up_io (
      .BASE  (iob_q[i]),
      .LIMIT (io_top[i]),
      .ADDR  (CB_IO_ADDR),
      .HIT   (up_io_c[i])
    );
  end

  // line byte, prefetch flags and ties
  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      line_q <= RST_LINE;
      pf_q   <= RST_PF;
      tie_q  <= RST_TIE;
    end
    else if (CLK_EN && wr_go)
    begin
      if (wr_sel == SEL_IRQ)
      begin
        // line byte is stored only; routing never reads it
        line_q <= irq_wr[LINE_LSB +: 8];
        pf_q   <= irq_wr[PF1_BIT:PF0_BIT];
      end
      else if (wr_sel == SEL_TIE)
        tie_q <= tie_wr[1:0];
    end
  end

  // read data path; reserved bits read zero, stored in the window words, fixed in the interrupt and tie words
  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= RESP_OKAY;
    end
    else if (CLK_EN)
    begin
      if (rd_go)
      begin
        rvalid_q <= 1'b1;
        rresp_q  <= RESP_OKAY;
        case (rd_sel)
          SEL_MBASE0: rdata_q <= mbase_q[0];
          SEL_MBASE1: rdata_q <= mbase_q[1];
          SEL_MLIM0:  rdata_q <= mlim_q[0];
          SEL_MLIM1:  rdata_q <= mlim_q[1];
          SEL_IOB0:   rdata_q <= iob_q[0];
          SEL_IOB1:   rdata_q <= iob_q[1];
          SEL_IOL0:   rdata_q <= iol_q[0];
          SEL_IOL1:   rdata_q <= iol_q[1];
          SEL_IRQ:    rdata_q <= {6'h0, pf_q, 8'h00, pin_f0, line_q};
          SEL_TIE:    rdata_q <= {30'h0, tie_q};
          default:
          begin
            rdata_q <= 32'h0000_0000;
            rresp_q <= RESP_SLVERR;
          end
        endcase
      end
      else if (S_AXI_RREADY)
        rvalid_q <= 1'b0;
    end
  end

  // registered decode results; one cycle behind the address
  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      DN_MEM_HIT      <= 2'h0;
      DN_MEM_PREFETCH <= 2'h0;
      UP_MEM_HIT      <= 2'h0;
      DN_IO_HIT       <= 2'h0;
      UP_IO_HIT       <= 2'h0;
    end
    else if (CLK_EN)
    begin
      DN_MEM_HIT      <= dn_mem_c;
      DN_MEM_PREFETCH <= dn_mem_c & pf_q;
      UP_MEM_HIT      <= up_mem_c;
      DN_IO_HIT       <= dn_io_c;
      UP_IO_HIT       <= up_io_c;
    end
  end

  // tie settings leave the block for the interrupt router
  assign TIE_SECOND_IRQ_TO_FIRST = tie_q[TIE2_BIT];
  assign TIE_ALL_IRQ_LINES       = tie_q[TALL_BIT];

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);

  property p_mlim_wr;
    (wr_go && wr_sel == SEL_MLIM0 && wstrb_q == 4'hF) |=>
      mlim_q[0] == ($past(wdata_q) & 32'hFFFF_F000);
  endproperty
  a_mlim_wr: assert property (p_mlim_wr)
    else $error("memory limit write wrong");

  property p_mem_off;
    (CLK_EN && mbase_q[0] == 32'h0 && mlim_q[0] == 32'h0) |=> !DN_MEM_HIT[0];
  endproperty
  a_mem_off: assert property (p_mem_off)
    else $error("closed memory window hit");

  property p_pf;
    CLK_EN |=> DN_MEM_PREFETCH == (DN_MEM_HIT & $past(pf_q));
  endproperty
  a_pf: assert property (p_pf)
    else $error("prefetch flag wrong");

  property p_iob_rd;
    (rd_go && rd_sel == SEL_IOB1) |=> rvalid_q && (rdata_q & 32'hFFFF_0003) == 32'h0;
  endproperty
  a_iob_rd: assert property (p_iob_rd)
    else $error("io base reserved bits set");

  property p_io_top;
    (CLK_EN && iob_q[0] != 32'h0 && iob_q[0] <= io_top[0] &&
     PCI_IO_ADDR == (io_top[0] | 32'h3)) |=> DN_IO_HIT[0];
  endproperty
  a_io_top: assert property (p_io_top)
    else $error("io limit dword not covered");

  property p_io_off;
    (CLK_EN && iob_q[1] == 32'h0 && iol_q[1] == 32'h0) |=> !DN_IO_HIT[1] && !UP_IO_HIT[1];
  endproperty
  a_io_off: assert property (p_io_off)
    else $error("closed io window hit");

  property p_iol_ro;
    (wr_go && wr_sel == SEL_IOL0 && wstrb_q == 4'hF && wdata_q == 32'hFFFF_FFFF) |=>
      iol_q[0] == 32'h0000_FFFC;
  endproperty
  a_iol_ro: assert property (p_iol_ro)
    else $error("io limit read-only bits changed");

  property p_line_rst;
    RST |=> line_q == 8'hFF;
  endproperty
  a_line_rst: assert property (disable iff (1'b0) p_line_rst)
    else $error("line byte reset wrong");

  property p_pin;
    (rd_go && rd_sel == SEL_IRQ) |=> rdata_q[15:8] == 8'h01;
  endproperty
  a_pin: assert property (p_pin)
    else $error("pin byte not one");

  c_wr: cover property (wr_go && wr_sel == SEL_MLIM1);
  c_rd: cover property (rd_go && rd_sel == SEL_IOL0);
  c_hit: cover property (DN_IO_HIT[0] && DN_MEM_HIT[1]);
endmodule // cbw_regs

// ===== testbench/cbw_bus_model.sv
// cycle address source standing in for the pci host and the card bus card
`timescale 1ns/1ps
module cbw_bus_model
  import cbw_pkg::*;
(
  input  wire logic        clk,
  input  wire logic [31:0] pci_addr,
  input  wire logic [31:0] cb_addr,
  output logic [31:0]      pci_mem_addr,
  output logic [31:0]      pci_io_addr,
  output logic [31:0]      cb_mem_addr,
  output logic [31:0]      cb_io_addr
);
  // one cycle per side per clock; memory and io share it
  // so a swap of the two spaces shows as a wrong hit
  always_ff @(posedge clk)
  begin
    pci_mem_addr <= pci_addr;
    pci_io_addr  <= pci_addr;
    cb_mem_addr  <= cb_addr;
    cb_io_addr   <= cb_addr;
  end
endmodule // cbw_bus_model

// ===== testbench/testbench.sv
// self-checking bench for the window decode register bank
`timescale 1ns/1ps
module testbench
  import cbw_pkg::*;
;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e; logic [1:0] rs;} cbw_row_type;
  typedef struct {logic [31:0] a; logic [1:0] m; logic [1:0] i;} cbw_hit_type;
  logic        clk = 1'h0;      // core clock
  logic        rst = 1'h1;      // sync reset
  logic        clk_en = 1'h1;   // run enable
  logic [7:0]  awaddr = 8'h00;  // write address
  logic        awvalid = 1'h0;
  logic        awready;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'hF;    // full words except the byte-lane step
  logic        wvalid = 1'h0;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready = 1'h1;   // always willing to take answers
  logic [7:0]  araddr = 8'h00;
  logic        arvalid = 1'h0;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready = 1'h1;
  logic [31:0] pci_a = 32'h0;   // cycle address on pci
  logic [31:0] cb_a = 32'h0;    // cycle address on card bus
  logic [31:0] pma, pia, cma, cia;
  logic [1:0]  dmh, dpf, umh, dih, uih;
  logic        tie2, tall;
  logic [1:0]  pf = 2'h3;       // prefetch flags expected now
  logic [1:0]  r;
  logic [31:0] v;
  int          n_fail = 0;
  int          samples_checked = 0;
  // ordinary register cases: address, written, read back, response
  cbw_row_type rows [10] = '{
    '{8'h20, 32'hFFFF_FFFF, 32'hFFFF_F000, 2'h0}, '{8'h28, 32'h1234_5ABC, 32'h1234_5000, 2'h0},
    '{8'h1C, 32'h1000_0FFF, 32'h1000_0000, 2'h0}, '{8'h2C, 32'hFFFF_FFFF, 32'h0000_FFFC, 2'h0},
    '{8'h30, 32'hFFFF_FFFF, 32'h0000_FFFC, 2'h0}, '{8'h34, 32'h0001_2347, 32'h0000_2344, 2'h0},
    '{8'h38, 32'hFFFF_0003, 32'h0000_0000, 2'h0}, '{8'h3C, 32'h0000_005A, 32'h0000_015A, 2'h0},
    '{8'h3C, 32'hFFFF_FFFF, 32'h0300_01FF, 2'h0}, '{8'h44, 32'hFFFF_FFFF, 32'h0000_0000, 2'h2}};
  // window set-up for decode: two memory windows, io window 0 only
  cbw_row_type prog [9] = '{
    '{8'h1C, 32'h1000_0000, 0, 0}, '{8'h20, 32'h1000_1000, 0, 0}, '{8'h24, 32'h2000_0000, 0, 0},
    '{8'h28, 32'h2000_0000, 0, 0}, '{8'h2C, 32'h0000_0100, 0, 0}, '{8'h30, 32'h0000_01FC, 0, 0},
    '{8'h34, 32'h0000_0000, 0, 0}, '{8'h38, 32'h0000_0000, 0, 0}, '{8'h3C, 32'h0100_0000, 0, 0}};
  // edges of each window, one step inside and outside; memory window 1 top edge only
  cbw_hit_type hits [11] = '{
    '{32'h0000_0000, 2'h0, 2'h0}, '{32'h0FFF_FFFF, 2'h0, 2'h0}, '{32'h1000_0000, 2'h1, 2'h0},
    '{32'h1000_1FFF, 2'h1, 2'h0}, '{32'h1000_2000, 2'h0, 2'h0}, '{32'h2000_0FFF, 2'h2, 2'h0},
    '{32'h0000_00FF, 2'h0, 2'h0}, '{32'h0000_0100, 2'h0, 2'h1}, '{32'h0000_01FF, 2'h0, 2'h1},
    '{32'h0000_0200, 2'h0, 2'h0}, '{32'h0001_0100, 2'h0, 2'h0}};

  // 50 MHz core clock
  always #10 clk = ~clk;

  cbw_bus_model cbw_bus_model_inst (.clk(clk), .pci_addr(pci_a), .cb_addr(cb_a),
    .pci_mem_addr(pma), .pci_io_addr(pia), .cb_mem_addr(cma), .cb_io_addr(cia));

  cbw_regs cbw_regs_inst (.CORE_CLK(clk), .RST(rst), .CLK_EN(clk_en),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .PCI_MEM_ADDR(pma), .PCI_IO_ADDR(pia), .CB_MEM_ADDR(cma), .CB_IO_ADDR(cia),
    .DN_MEM_HIT(dmh), .DN_MEM_PREFETCH(dpf), .UP_MEM_HIT(umh), .DN_IO_HIT(dih),
    .UP_IO_HIT(uih), .TIE_SECOND_IRQ_TO_FIRST(tie2), .TIE_ALL_IRQ_LINES(tall));

  // verdict and end of run
  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // one compare, counted
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one write; address and data offered together, each dropped once taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rsp);
    int n;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge clk);
      if (awvalid && awready)
        awvalid <= 1'h0;
      if (wvalid && wready)
        wvalid <= 1'h0;
      if (bvalid)
        break;
    end
    rsp = bresp;
    // a missing answer counts against the run
    if (n == 50)
      chk(32'h0, 32'h1);
  endtask

  // one read; data taken at the edge that shows rvalid
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rsp);
    int n;
    araddr <= a;
    arvalid <= 1'h1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge clk);
      if (arvalid && arready)
        arvalid <= 1'h0;
      if (rvalid)
        break;
    end
    d = rdata;
    rsp = rresp;
    if (n == 50)
      chk(32'h0, 32'h1);
  endtask

  // present one cycle address to both sides; hits sampled three edges on
  task automatic hit(input logic [31:0] a, input logic [1:0] em, input logic [1:0] ei);
    pci_a <= a;
    cb_a <= a;
    repeat (3) @(posedge clk);
    chk({26'h0, dmh, umh, dpf}, {26'h0, em, em, em & pf});
    chk({28'h0, dih, uih}, {28'h0, ei, ei});
  endtask

  // cut a hang short well past the expected run length
  initial
  begin
    #1_000_000;
    n_fail++;
    test_done();
  end

  // main sequence
  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    for (int i = 0; i < 10; i++)
    begin
      axr(8'h1C + 8'(4 * i), v, r);
      chk(v, (i == 8) ? 32'h0300_01FF : 32'h0);
    end
    hit(32'h0000_0000, 2'h0, 2'h0);
    hit(32'h0000_0FFF, 2'h0, 2'h0);
    $display("reset values done");
    // register table: masks, read-only bits, unmapped offset
    foreach (rows[i])
    begin
      axw(rows[i].a, rows[i].d, r);
      chk({30'h0, r}, {30'h0, rows[i].rs});
      axr(rows[i].a, v, r);
      chk(v, rows[i].e);
      chk({30'h0, r}, {30'h0, rows[i].rs});
    end
    $display("register table done");
    // decode against programmed windows, prefetch only on window 0
    foreach (prog[i])
      axw(prog[i].a, prog[i].d, r);
    pf = 2'h1;
    foreach (hits[i])
      hit(hits[i].a, hits[i].m, hits[i].i);
    $display("decode done");
    // every tie setting leaves the function zero pin byte at one
    for (int t = 0; t < 4; t++)
    begin
      axw(8'h40, 32'(t), r);
      axr(8'h3C, v, r);
      chk({30'h0, tall, tie2}, 32'(t));
      chk({24'h0, v[15:8]}, {24'h0, PIN_A});
    end
    $display("tie settings done");
    // one byte lane only: line byte moves, prefetch flags and pin stay
    wstrb <= 4'h1;
    axw(8'h3C, 32'hFFFF_FF33, r);
    wstrb <= 4'hF;
    axr(8'h3C, v, r);
    chk(v, 32'h0100_0133);
    $display("byte lanes done");
    // enable low drops every ready and freezes the hit outputs
    clk_en <= 1'h0;
    pci_a <= 32'h1000_0000;
    repeat (3) @(posedge clk);
    chk({29'h0, awready, wready, arready}, 32'h0);
    chk({30'h0, dmh}, 32'h0);
    clk_en <= 1'h1;
    repeat (2) @(posedge clk);
    chk({30'h0, dmh}, 32'h1);
    $display("enable freeze done");
    // second reset mid-run clears windows and restores defaults
    rst <= 1'h1;
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    axr(8'h20, v, r);
    chk(v, 32'h0);
    axr(8'h3C, v, r);
    chk(v, 32'h0300_01FF);
    pf = 2'h3;
    hit(32'h1000_0000, 2'h0, 2'h0);
    $display("mid-run reset done");
    test_done();
  end
endmodule // testbench
